// [core/two_wire_status_flags.sv]
`timescale 1ns/1ps
`default_nettype none
// Status flags of the two-wire controller with a Wishbone slave
module two_wire_status_flags (
  input  wire logic                                    i_clk,        // System clock
  input  wire logic                                    i_resetn,     // Sync reset, low
  // Wishbone classic slave
  input  wire logic                                    i_wb_cyc,     // Cycle
  input  wire logic                                    i_wb_stb,     // Strobe
  input  wire logic                                    i_wb_we,      // Write enable
  input  wire logic [two_wire_status_pkg::ADDR_W-1:0]  i_wb_adr,     // Byte address
  input  wire logic [3:0]                              i_wb_sel,     // Byte lanes
  input  wire logic [two_wire_status_pkg::DATA_W-1:0]  i_wb_dat,     // Write data
  output logic      [two_wire_status_pkg::DATA_W-1:0]  o_wb_dat,     // Read data
  output logic                                         o_wb_ack,     // Acknowledge
  // Bus pins
  input  wire logic                                    i_scl,        // Clock line in
  input  wire logic                                    i_sda,        // Data line in
  output logic                                         o_scl_out,    // Clock line drive
  output logic                                         o_scl_oe,     // Clock line enable
  // Sequencer events, same clock
  input  wire logic                                    i_match,      // Address match
  input  wire logic                                    i_gc_match,   // General call hit
  input  wire logic                                    i_addr_ok,    // Address sent ok
  input  wire logic                                    i_tx_nack,    // Byte not acked
  input  wire logic                                    i_byte_done,  // Byte needs service
  input  wire logic                                    i_arb_lost,   // Bus conflict
  input  wire logic                                    i_master_won, // Became master
  input  wire logic                                    i_dir_tx,     // Transmit direction
  input  wire logic [7:0]                              i_rx_byte,    // Received byte
  // System power state
  input  wire logic                                    i_idle_mode,  // Idle low power
  input  wire logic                                    i_halt_mode,  // Halt low power
  // Outputs to the rest of the controller
  output logic      [7:0]                              o_tx_byte,    // Byte to send
  output logic                                         o_suspend,    // Bus activity held
  output logic                                         o_slave_mode, // Acting as slave
  output logic                                         o_dma_req,    // DMA request
  output logic                                         o_irq         // Interrupt request
);
  import two_wire_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and condition detection
  logic [SYNC_N-1:0] pins_sync;  // Synchronised clock and data
  logic              cond_start; // Start pulse
  logic              cond_stop;  // Stop pulse
  logic              scl_rise;   // Clock rise pulse
  logic              scl_fall;   // Clock fall pulse

  pin_sync u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_sda, i_scl}),
    .o_sync   (pins_sync)
  );

  bus_condition_detect u_detect (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_scl      (pins_sync[0]),
    .i_sda      (pins_sync[1]),
    .o_start    (cond_start),
    .o_stop     (cond_stop),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]    status_reg;     // Status flags
  logic [7:0]    status_next;
  logic [7:0]    control_reg;    // Control bits
  logic [7:0]    control_next;
  logic [7:0]    data_reg;       // Transmit byte
  logic [7:0]    data_next;
  logic          ack_reg;        // Bus acknowledge
  logic          ack_next;
  logic [31:0]   rdat_reg;       // Read data
  logic [31:0]   rdat_next;
  bus_state_type bus_reg;        // Bus activity
  bus_state_type bus_next;
  logic [3:0]    cnt_reg;        // Clock rises in byte
  logic [3:0]    cnt_next;
  logic          slv_act_reg;    // Matched slave transfer open
  logic          slv_act_next;

  // Decoded accesses
  logic access;     // Request present
  logic commit;     // Request completes this edge
  logic wr_lane0;   // Write with low lane
  logic hit_data;   // Data register addressed
  logic hit_stat;   // Status register addressed
  logic hit_ctrl;   // Control register addressed
  logic wipe;       // Status and bus-state clear condition
  logic illegal;    // Misplaced start or stop
  logic any_match;  // Own or general-call match

  // Address compare used for three registers
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  always_comb begin
    access    = i_wb_cyc & i_wb_stb;
    commit    = access & ack_reg;
    wr_lane0  = commit & i_wb_we & i_wb_sel[0];
    hit_data  = addr_is(i_wb_adr, OFS_DATA);
    hit_stat  = addr_is(i_wb_adr, OFS_STATUS);
    hit_ctrl  = addr_is(i_wb_adr, OFS_CONTROL);
    any_match = i_match | i_gc_match;
    // Low-power entry or disable wipes the flags
    wipe      = ~control_reg[CT_ENABLE] | i_idle_mode | i_halt_mode;
    // Start or stop during bits 2..8 or the ack slot
    illegal   = (cond_start | cond_stop) & (bus_reg == BUS_ACTIVE)
                & (cnt_reg >= CNT_ILL_LO) & (cnt_reg <= CNT_ACK);
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, dropped next cycle
  always_comb begin
    ack_next  = access & ~ack_reg;
    rdat_next = rdat_reg;
    if (!i_resetn) begin
      ack_next  = 1'b0;
      rdat_next = 32'h0000_0000;
    end else if (access & ~ack_reg) begin
      // Unmapped addresses answer with zero
      rdat_next = 32'h0000_0000;
      if (hit_data) begin
        rdat_next[7:0] = i_rx_byte;
      end else if (hit_stat) begin
        rdat_next[7:0] = status_reg;
      end else if (hit_ctrl) begin
        rdat_next[7:0] = control_reg;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    ack_reg  <= ack_next;
    rdat_reg <= rdat_next;
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control and transmit data registers
  always_comb begin
    control_next = control_reg;
    data_next    = data_reg;
    if (!i_resetn) begin
      control_next = CONTROL_RST;
      data_next    = DATA_RST;
    end else begin
      if (wr_lane0 & hit_ctrl) begin
        control_next = i_wb_dat[7:0];
      end else if (i_addr_ok | wipe) begin
        // Start request ends once the address is out
        control_next[CT_START] = 1'b0;
      end
      if (wr_lane0 & hit_data) begin
        data_next = i_wb_dat[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    control_reg <= control_next;
    data_reg    <= data_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus tracking: activity state and bit position
  always_comb begin
    bus_next     = bus_reg;
    cnt_next     = cnt_reg;
    slv_act_next = slv_act_reg;
    case (bus_reg)
      BUS_IDLE: begin
        if (cond_start) begin
          bus_next = BUS_ACTIVE;
          cnt_next = CNT_ZERO;
        end
      end
      BUS_ACTIVE: begin
        if (cond_stop) begin
          bus_next = BUS_IDLE;
        end else if (cond_start) begin
          // Repeated start begins a fresh address byte
          cnt_next = CNT_ZERO;
        end else if (scl_rise) begin
          cnt_next = cnt_reg + CNT_ONE;
        end else if (scl_fall & (cnt_reg == CNT_ACK)) begin
          cnt_next = CNT_ZERO;
        end
      end
      default: begin
        bus_next = BUS_IDLE;
        cnt_next = CNT_ZERO;
      end
    endcase
    // Matched slave transfer stays open until start or stop
    if (any_match) begin
      slv_act_next = 1'b1;
    end else if (cond_start | cond_stop) begin
      slv_act_next = 1'b0;
    end
    if (!i_resetn | wipe) begin
      bus_next     = BUS_IDLE;
      cnt_next     = CNT_ZERO;
      slv_act_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    bus_reg     <= bus_next;
    cnt_reg     <= cnt_next;
    slv_act_reg <= slv_act_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: hardware set always beats a software clear
  logic [7:0] w1c;        // Write-one-clear mask from software
  logic       bw_clear;   // Data access clears buffer flag
  logic       bw_set;     // Buffer needs service
  logic       st_set;     // Stall after address sent

  always_comb begin
    w1c = 8'h00;
    // Only these five take write-one-clear; the rest ignore writes
    if (wr_lane0 & hit_stat) begin
      w1c[ST_NEW_MATCH_FLAG] = i_wb_dat[ST_NEW_MATCH_FLAG];
      w1c[ST_STALL]  = i_wb_dat[ST_STALL];
      w1c[ST_NACK]   = i_wb_dat[ST_NACK];
      w1c[ST_BERR]   = i_wb_dat[ST_BERR];
      w1c[ST_SSTOP]  = i_wb_dat[ST_SSTOP];
    end
    // Read in receive, write in transmit; start bit protects reads
    bw_clear = commit & hit_data &
               ((i_wb_we & i_wb_sel[0] & status_reg[ST_DIR]) |
                (~i_wb_we & ~status_reg[ST_DIR]
                 & ~control_reg[CT_START]));
    // A nacked byte never asks for the next one
    bw_set = (i_byte_done & ~i_tx_nack)
             | (any_match & i_dir_tx);
    // Stall only counts while master and enabled
    st_set = i_addr_ok & status_reg[ST_MASTER]
             & control_reg[CT_STALLE] & ~i_tx_nack & ~i_arb_lost;
  end

  always_comb begin
    status_next = status_reg;
    // Write-one-clear first, hardware sets on top
    status_next = status_reg & ~w1c;
    if (any_match) begin
      status_next[ST_NEW_MATCH_FLAG] = 1'b1;
    end
    if (st_set) begin
      status_next[ST_STALL] = 1'b1;
    end
    if (i_tx_nack) begin
      status_next[ST_NACK] = 1'b1;
    end
    if (illegal | i_arb_lost) begin
      status_next[ST_BERR] = 1'b1;
    end
    if (cond_stop & slv_act_reg) begin
      status_next[ST_SSTOP] = 1'b1;
    end
    // Buffer flag: set wins over the access clear
    if (bw_set) begin
      status_next[ST_BUFW] = 1'b1;
    end else if (bw_clear | i_tx_nack) begin
      status_next[ST_BUFW] = 1'b0;
    end
    // Master and direction follow the bus, never software
    status_next[ST_DIR] = i_dir_tx;
    if (i_arb_lost) begin
      status_next[ST_MASTER] = 1'b0;
    end else if (i_master_won) begin
      status_next[ST_MASTER] = 1'b1;
    end
    if (!i_resetn | wipe) begin
      status_next = STATUS_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    status_reg <= status_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Stall pulls the clock line low; the line is open drain
  assign o_scl_out = 1'b0;
  assign o_scl_oe  = status_reg[ST_STALL];
  assign o_suspend = status_reg[ST_STALL];
  assign o_tx_byte = data_reg;

  // Slave whenever enabled and not master
  assign o_slave_mode = control_reg[CT_ENABLE] & ~status_reg[ST_MASTER];

  // DMA held off while a new match waits for software
  assign o_dma_req = control_reg[CT_DMAEN] & status_reg[ST_BUFW]
                     & ~status_reg[ST_NEW_MATCH_FLAG];

  // Level interrupt while match or stall pending and enabled
  assign o_irq = control_reg[CT_INTERRUPT_ENABLE_BIT] &
                 (status_reg[ST_NEW_MATCH_FLAG]
                  | status_reg[ST_STALL]);
endmodule
`default_nettype wire

// [include/two_wire_status_pkg.sv]
// Function
// - Eight-bit status, five flags write-one-to-clear
// - Reset, idle, halt, disable clear status
// - Address or general-call match sets bit 2
// - New match blocks DMA, may interrupt
// - Master stall flag bit 3 after address
// - Stall holds clock low, suspends bus
// - Stall flag raises interrupt when enabled
// - Unacknowledged transmit byte sets bit 4
// - Negative acknowledge leaves buffer flag clear
// - Misplaced start/stop or arbitration sets bit 5
// - Buffer-waiting bit 6 when data needs service
// - Data access clears buffer-waiting flag
// - Start bit blocks read-clear of buffer flag
// - Stop after matched slave transfer sets bit 7
// - Bus conflict: error set, master cleared
// - Match in transmit sets buffer-waiting flag
// - Enabled without master flag acts as slave
package two_wire_status_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam int         REG_W       = 8;
  // Status bit positions
  localparam int ST_DIR    = 0;
  localparam int ST_MASTER = 1;
  localparam int ST_NEW_MATCH_FLAG = 2;
  localparam int ST_STALL  = 3;
  localparam int ST_NACK   = 4;
  localparam int ST_BERR   = 5;
  localparam int ST_BUFW   = 6;
  localparam int ST_SSTOP  = 7;
  // Control bit positions
  localparam int CT_ENABLE = 0;
  localparam int CT_INTERRUPT_ENABLE_BIT  = 1;
  localparam int CT_STALLE = 2;
  localparam int CT_START  = 3;
  localparam int CT_DMAEN  = 4;
  // Reset values
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  // Bit counter: rises per byte, first and last illegal positions
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;
  localparam logic [3:0] CNT_ILL_LO  = 4'h2;
  localparam logic [3:0] CNT_ACK     = 4'h9;
  localparam int         SYNC_N      = 2;
  // Bus activity state
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACTIVE = 2'b10
  } bus_state_type;
endpackage

// [core/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for the bus pins
module pin_sync (
  input  wire logic                                  i_clk,    // System clock
  input  wire logic                                  i_resetn, // Sync reset, low
  input  wire logic [two_wire_status_pkg::SYNC_N-1:0] i_async,  // Raw pin levels
  output logic      [two_wire_status_pkg::SYNC_N-1:0] o_sync    // Synchronised levels
);
  import two_wire_status_pkg::*;

  logic [SYNC_N-1:0] meta_reg;  // First stage, read only by second
  logic [SYNC_N-1:0] sync_reg;  // Second stage
  logic [SYNC_N-1:0] meta_next;
  logic [SYNC_N-1:0] sync_next;

  ////////////////////////////////////////////////////////////////////////
  // Idle bus is high, so reset to ones avoids a false start
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_bit
      always_comb begin
        meta_next[g] = i_resetn ? i_async[g] : 1'b1;
        sync_next[g] = i_resetn ? meta_reg[g] : 1'b1;
      end
    end
  endgenerate

  // Register both stages
  always_ff @(posedge i_clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// [core/bus_condition_detect.sv]
`timescale 1ns/1ps
`default_nettype none
// Start, stop and clock edge detection on synchronised lines
module bus_condition_detect (
  input  wire logic i_clk,      // System clock
  input  wire logic i_resetn,   // Sync reset, low
  input  wire logic i_scl,      // Synchronised clock line
  input  wire logic i_sda,      // Synchronised data line
  output logic      o_start,    // Start seen, pulse
  output logic      o_stop,     // Stop seen, pulse
  output logic      o_scl_rise, // Clock rising, pulse
  output logic      o_scl_fall  // Clock falling, pulse
);
  import two_wire_status_pkg::*;

  logic scl_d_reg;  // Previous clock level
  logic sda_d_reg;  // Previous data level
  logic scl_d_next;
  logic sda_d_next;

  ////////////////////////////////////////////////////////////////////////
  // Delay copies; idle high after reset
  always_comb begin
    scl_d_next = i_resetn ? i_scl : 1'b1;
    sda_d_next = i_resetn ? i_sda : 1'b1;
  end

  always_ff @(posedge i_clk) begin
    scl_d_reg <= scl_d_next;
    sda_d_reg <= sda_d_next;
  end

  // Data change while clock high marks start or stop
  assign o_start    = scl_d_reg & i_scl & sda_d_reg & ~i_sda;
  assign o_stop     = scl_d_reg & i_scl & ~sda_d_reg & i_sda;
  assign o_scl_rise = ~scl_d_reg & i_scl;
  assign o_scl_fall = scl_d_reg & ~i_scl;
endmodule
`default_nettype wire

// [bench/two_wire_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Port checker for the status flag block
module two_wire_status_monitor (
  input wire logic        i_clk,        // Clock
  input wire logic        i_resetn,     // Reset, low
  input wire logic        i_wb_cyc,     // Cycle
  input wire logic        i_wb_stb,     // Strobe
  input wire logic        i_wb_we,      // Write
  input wire logic [7:0]  i_wb_adr,     // Address
  input wire logic [3:0]  i_wb_sel,     // Lanes
  input wire logic [31:0] i_wb_dat,     // Write data
  input wire logic        o_wb_ack,     // Acknowledge
  input wire logic        o_scl_out,    // Clock drive level
  input wire logic        o_scl_oe,     // Clock drive enable
  input wire logic        i_match,      // Own match
  input wire logic        i_gc_match,   // General call
  input wire logic        i_addr_ok,    // Address sent
  input wire logic        i_tx_nack,    // Not acked
  input wire logic        i_byte_done,  // Byte service
  input wire logic        i_arb_lost,   // Conflict
  input wire logic        i_master_won, // Became master
  input wire logic        i_idle_mode,  // Idle
  input wire logic        i_halt_mode,  // Halt
  input wire logic        o_suspend,    // Bus held
  input wire logic        o_slave_mode, // Slave role
  input wire logic        o_dma_req,    // DMA request
  input wire logic        o_irq         // Interrupt
);
  logic [7:0] ctl_reg;  // Control mirror
  logic [7:0] ctl_next; // Next mirror
  logic       wr_ctl;   // Control written now
  logic       quiet;    // No low-power mode or control write this cycle
  assign wr_ctl = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0] & (i_wb_adr == 8'h0C);
  assign quiet  = !i_idle_mode && !i_halt_mode && !wr_ctl;
  ////////////////////////////////////////////////////////////////
  // Mirror control at the ack edge, the same edge the block uses
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) begin
      ctl_next = i_wb_dat[7:0];
    end
  end
  always_ff @(posedge i_clk) begin
    ctl_reg <= i_resetn ? ctl_next : 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  sequence s_stall_on;
    o_scl_oe && o_suspend && !o_scl_out;
  endsequence
  AST_ACK_ONE: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> s_ack_pulse)
    else $error("ack is not one cycle after request");
  AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_irq && !o_dma_req && !o_scl_oe)
    else $error("outputs active after reset");
  AST_CLEAR_ALL: assert property (i_idle_mode || i_halt_mode |=> !o_irq && !o_dma_req && !o_suspend)
    else $error("low power did not wipe status");
  AST_MATCH_IRQ: assert property (i_match && quiet && ctl_reg[0] && ctl_reg[1] |=> o_irq)
    else $error("match gave no interrupt");
  AST_DMA_BLOCK: assert property (i_match && quiet && ctl_reg[0] |=> !o_dma_req)
    else $error("dma request during new match");
  AST_STALL_SET: assert property (
    i_addr_ok && quiet && ctl_reg[0] && ctl_reg[2] && !o_slave_mode && !i_tx_nack && !i_arb_lost
    |=> s_stall_on)
    else $error("stall not set after address");
  AST_SLAVE_NO_STALL: assert property (o_slave_mode && !o_suspend && !i_master_won |=> !o_suspend)
    else $error("stall set in slave role");
  AST_STALL_PIN: assert property (o_suspend |-> s_stall_on)
    else $error("stall does not hold clock low");
  AST_STALL_IRQ: assert property (o_suspend && ctl_reg[1] |-> o_irq)
    else $error("stall gave no interrupt");
  AST_NACK_NODMA: assert property (i_tx_nack |=> !o_dma_req)
    else $error("buffer flag set after nack");
  AST_BUFW_DMA: assert property (
    i_byte_done && !i_tx_nack && !i_match && !i_gc_match && quiet && !o_irq
    && ctl_reg[0] && ctl_reg[1] && ctl_reg[4] |=> o_dma_req)
    else $error("byte service gave no dma request");
  AST_ARB_SLAVE: assert property (i_arb_lost && !i_master_won && quiet && ctl_reg[0] |=> o_slave_mode)
    else $error("conflict kept master role");
endmodule
bind two_wire_status_flags two_wire_status_monitor u_mon (.*);
`default_nettype wire

// [bench/bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Another master on the wire; lines idle high by pull-up
module bus_partner (
  output logic o_scl, // Clock line, still outside frames
  output logic o_sda  // Data line
);
  localparam realtime HALF = 62.5; // Half of a 125 ns link clock
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Data falls while clock high
  task automatic start();
    o_sda = 1'h0;
    #HALF o_scl = 1'h0;
    #HALF;
  endtask
  // Clock pulses; data changes only while clock is low
  task automatic clk(input int n);
    repeat (n) begin
      o_sda = ~o_sda;
      #HALF o_scl = 1'h1;
      #HALF o_scl = 1'h0;
    end
  endtask
  // Start again without a stop
  task automatic restart();
    o_sda = 1'h1;
    #HALF o_scl = 1'h1;
    #HALF o_sda = 1'h0;
    #HALF o_scl = 1'h0;
    #HALF;
  endtask
  // Data rises while clock high
  task automatic stop();
    o_sda = 1'h0;
    #HALF o_scl = 1'h1;
    #HALF o_sda = 1'h1;
    #HALF;
  endtask
endmodule
`default_nettype wire

// [bench/two_wire_status_flags_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_status_flags_tb;
  logic        i_clk = 1'h0;       // 250 MHz clock
  logic        i_resetn = 1'h0;    // Reset, low
  logic        i_wb_cyc = 1'h0;    // Bus cycle
  logic        i_wb_stb = 1'h0;    // Bus strobe
  logic        i_wb_we = 1'h0;     // Bus write
  logic [7:0]  i_wb_adr = 8'h00;   // Bus address
  logic [3:0]  i_wb_sel = 4'hF;    // All lanes
  logic [31:0] i_wb_dat = 32'h0;   // Write data
  logic [31:0] o_wb_dat;           // Read data
  logic        o_wb_ack;           // Bus ack
  logic        o_scl_out;          // Clock drive level
  logic        o_scl_oe;           // Clock drive enable
  logic [6:0]  ev = 7'h00;         // Event pulses
  logic        i_dir_tx = 1'h0;    // Direction
  logic [7:0]  i_rx_byte = 8'h00;  // Received byte
  logic        i_idle_mode = 1'h0; // Idle
  logic        i_halt_mode = 1'h0; // Halt
  logic [7:0]  o_tx_byte;          // Byte to send
  logic        o_suspend;          // Bus held
  logic        o_slave_mode;       // Slave role
  logic        o_dma_req;          // DMA request
  logic        o_irq;              // Interrupt
  wire logic   bus_scl;            // Partner clock
  wire logic   i_sda;              // Data line
  wire logic   i_scl = bus_scl & ~o_scl_oe; // Wired clock line
  wire logic   i_match = ev[0];
  wire logic   i_gc_match = ev[1];
  wire logic   i_addr_ok = ev[2];
  wire logic   i_tx_nack = ev[3];
  wire logic   i_byte_done = ev[4];
  wire logic   i_arb_lost = ev[5];
  wire logic   i_master_won = ev[6];
  int          num_errors = 0;     // Mismatches
  int          checks = 0;         // Comparisons
  logic [31:0] expq[$];            // Expected read data
  logic [7:0]  rnd = 8'h0A;        // Random state
  two_wire_status_flags u_dut (.*);
  bus_partner u_bus (.o_scl(bus_scl), .o_sda(i_sda));
  always #2 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is seen at an edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    do @(posedge i_clk); while (o_wb_ack !== 1'h1);
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    i_wb_we <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'h0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  // One-cycle event; flag visible on return
  task automatic pulse(input logic [6:0] v);
    ev <= v;
    @(posedge i_clk);
    ev <= 7'h00;
    @(posedge i_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reads compared against the oldest note
  always @(posedge i_clk) begin
    if (o_wb_ack === 1'h1 && i_wb_we === 1'h0) chk("rdata", expq.pop_front(), o_wb_dat);
  end
  // Ceiling well above the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge i_clk);
    num_errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'h1;
    @(posedge i_clk);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    wr(8'h0C, 8'h17);
    chk("slave", 1'h1, o_slave_mode);
    pulse(7'h04);
    rd(8'h04, 8'h00);
    pulse(7'h10);
    chk("dma", 1'h1, o_dma_req);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h40);
    pulse(7'h01);
    chk("dma", 1'h0, o_dma_req);
    chk("irq", 1'h1, o_irq);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h44);
    wr(8'h04, 8'h04);
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      i_rx_byte <= rnd;
      wr(8'h0C, k[0] ? 8'h17 : 8'h1F);
      rd(8'h00, rnd);
      rd(8'h04, k[0] ? 8'h00 : 8'h40);
      if (k < 4) pulse(7'h10);
    end
    $display("test receive done");
    pulse(7'h40);
    chk("slave", 1'h0, o_slave_mode);
    pulse(7'h04);
    rd(8'h04, 8'h4A);
    chk("scl_oe", 1'h1, o_scl_oe);
    chk("irq", 1'h1, o_irq);
    wr(8'h04, 8'h08);
    i_dir_tx <= 1'h1;
    pulse(7'h10);
    rnd = lfsr(rnd);
    wr(8'h00, rnd);
    chk("tx_byte", rnd, o_tx_byte);
    rd(8'h04, 8'h03);
    pulse(7'h18);
    rd(8'h04, 8'h13);
    pulse(7'h20);
    rd(8'h04, 8'h31);
    pulse(7'h01);
    rd(8'h04, 8'h75);
    wr(8'h04, 8'h34);
    wr(8'h00, rnd);
    i_dir_tx <= 1'h0;
    @(posedge i_clk);
    rd(8'h04, 8'h00);
    $display("test master done");
    u_bus.start();
    @(posedge i_clk);
    pulse(7'h02);
    u_bus.stop();
    repeat (2) @(posedge i_clk);
    rd(8'h04, 8'h84);
    wr(8'h04, 8'h84);
    u_bus.start();
    u_bus.clk(3);
    u_bus.restart();
    u_bus.stop();
    repeat (2) @(posedge i_clk);
    rd(8'h04, 8'h20);
    wr(8'h04, 8'h20);
    $display("test bus done");
    for (int k = 0; k < 3; k++) begin
      pulse(7'h01);
      if (k < 2) begin
        {i_halt_mode, i_idle_mode} <= k[1:0] + 2'h1;
        @(posedge i_clk);
        {i_halt_mode, i_idle_mode} <= 2'h0;
        @(posedge i_clk);
      end else begin
        wr(8'h0C, 8'h00);
      end
      rd(8'h04, 8'h00);
      wr(8'h0C, 8'h17);
    end
    $display("test wipe done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
